// *** hdl/slsb_pkg.sv ***
// Constants for the lock and side-band status register slice
// Notes on behaviour
// - Byte 33 is read-only and bits 7..0 return the side-band disable state of outputs 7..0.
// - Byte 34 is read-only and bits 7..0 return the side-band disable state of outputs 15..8.
// - Byte 35 is read-only, bits 3..0 return outputs 19..16 and bits 7..4 are reserved.
// - Each readback bit shows the disable level as it is, low as zero and high as one.
// - The readback bytes mean something only while the side-band port enable status is one.
// - Byte 38 bit 0 is a lock that resets to zero and, once written to one, blocks all later host writes.
// - That lock stays set whatever the host writes, and only reset clears it.
// - Byte 39 bit 0 is a clearable lock, reset zero, that blocks writes to registers outside this slice and toggles on each write of one.
// - Byte 39 bit 1 is a sticky input loss flag, reset zero, set on detected loss and cleared by writing one.
// - The loss flag is set from the detector's live level, which reads zero during a loss and is readable too; here only on lossLiveSync, not in byte 39.
package slsb_pkg;
  localparam logic [7:0] SLSB_OFS_RB_LOW = 8'h21;
  localparam logic [7:0] SLSB_OFS_RB_MID = 8'h22;
  localparam logic [7:0] SLSB_OFS_RB_HIGH = 8'h23;
  localparam logic [7:0] SLSB_OFS_PERM_LOCK = 8'h26;
  localparam logic [7:0] SLSB_OFS_CLR_LOCK = 8'h27;
  localparam int SLSB_NUM_OUT = 20;
  localparam int SLSB_HIGH_BITS = 4;
  localparam int SLSB_BIT_LOCK = 0;
  localparam int SLSB_BIT_LOSS = 1;
  localparam logic SLSB_LOCK_RST = 1'b0;
  localparam logic SLSB_LOSS_RST = 1'b0;
  localparam logic [7:0] SLSB_BYTE_RST = 8'h00;
endpackage : slsb_pkg

// *** hdl/slsb_regs.sv ***
// Register slice: side-band readback, write locks and loss event flag
`timescale 1ns/100ps
module slsb_regs (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdHit,
  output logic extWrEn,
  output logic writeProtect,
  input wire logic [slsb_pkg::SLSB_NUM_OUT-1:0] sbDisable,
  input wire logic sbPortEnable,
  input wire logic lossLive_n,
  output logic lossLiveSync,
  output logic permLock,
  output logic clrLock,
  output logic lossFlag
);
  import slsb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Loss detector level, from another domain
  logic lossMeta;
  logic lossSync;
  always_ff @(posedge mclk) begin
    if (reset) begin
      lossMeta <= 1'b1;
      lossSync <= 1'b1;
    end else begin
      lossMeta <= lossLive_n;
      lossSync <= lossMeta;
    end
  end
  assign lossLiveSync = lossSync;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic logic isLocal(input logic [7:0] a);
    isLocal = (a == SLSB_OFS_RB_LOW) || (a == SLSB_OFS_RB_MID) || (a == SLSB_OFS_RB_HIGH) ||
              (a == SLSB_OFS_PERM_LOCK) || (a == SLSB_OFS_CLR_LOCK);
  endfunction : isLocal

  wire protectAll = permLock;
  wire anyProtect = permLock | clrLock;
  wire wrPerm = regWrEn && (regAddr == SLSB_OFS_PERM_LOCK) && !protectAll;
  // Byte 39 stays writable under the clearable lock, else that lock could never be released
  wire wrClr = regWrEn && (regAddr == SLSB_OFS_CLR_LOCK) && !protectAll;
  wire setPerm = wrPerm && regWrData[SLSB_BIT_LOCK];
  wire lockToggle = wrClr && regWrData[SLSB_BIT_LOCK];
  wire lossClear = wrClr && regWrData[SLSB_BIT_LOSS];
  wire lossSeen = !lossSync;
  assign writeProtect = anyProtect;
  assign extWrEn = regWrEn && !isLocal(regAddr) && !anyProtect;

  ////////////////////////////////////////////////////////////////////////////
  // Lock and flag state
  wire next_permLock = permLock | setPerm;
  wire next_clrLock = lockToggle ? !clrLock : clrLock;
  // Set beats clear so a loss coinciding with the host clear is not lost
  wire next_lossFlag = lossSeen | (lossFlag & !lossClear);
  always_ff @(posedge mclk) begin
    if (reset) begin
      permLock <= SLSB_LOCK_RST;
      clrLock <= SLSB_LOCK_RST;
      lossFlag <= SLSB_LOSS_RST;
    end else begin
      permLock <= next_permLock;
      clrLock <= next_clrLock;
      lossFlag <= next_lossFlag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback; without the side-band port the bytes read zero
  // One gate per output; the disable level passes unchanged, only gated by the port status
  wire [SLSB_NUM_OUT-1:0] rbBits;
  for (genvar i = 0; i < SLSB_NUM_OUT; i++) begin : g_rb
    assign rbBits[i] = sbPortEnable & sbDisable[i];
  end
  wire [7:0] rbLow = rbBits[7:0];
  wire [7:0] rbMid = rbBits[15:8];
  wire [7:0] rbHigh = {4'h0, rbBits[SLSB_NUM_OUT-1:SLSB_NUM_OUT-SLSB_HIGH_BITS]};
  wire [7:0] permByte = {7'h00, permLock};
  wire [7:0] clrByte = {6'h00, lossFlag, clrLock};
  wire [7:0] next_rdData = (regAddr == SLSB_OFS_RB_LOW) ? rbLow :
                           (regAddr == SLSB_OFS_RB_MID) ? rbMid :
                           (regAddr == SLSB_OFS_RB_HIGH) ? rbHigh :
                           (regAddr == SLSB_OFS_PERM_LOCK) ? permByte :
                           (regAddr == SLSB_OFS_CLR_LOCK) ? clrByte : SLSB_BYTE_RST;
  always_ff @(posedge mclk) begin
    if (reset) begin
      regRdData <= SLSB_BYTE_RST;
      regRdHit <= 1'b0;
    end else if (regRdEn) begin
      regRdData <= next_rdData;
      regRdHit <= isLocal(regAddr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_perm_lock_sets: assert property (setPerm |=> permLock) else $error("lock did not set");
  a_perm_lock_holds: assert property (permLock |=> permLock) else $error("lock dropped");
  a_perm_blocks_ext: assert property (permLock |-> !extWrEn) else $error("write passed lock");
  a_clr_lock_flip: assert property (lockToggle |=> clrLock != $past(clrLock)) else $error("lock no toggle");
  a_clr_blocks_ext: assert property (clrLock |-> !extWrEn) else $error("write passed clr lock");
  a_blocked_no_change: assert property (permLock && regWrEn |=> $stable(clrLock) && permLock)
    else $error("blocked write changed state");
  a_loss_sets_flag: assert property (!lossLiveSync |=> lossFlag) else $error("loss not flagged");
  a_loss_sticky: assert property (lossFlag && !lossClear |=> lossFlag) else $error("flag fell");
  a_loss_sync_lag: assert property ($fell(lossLive_n) ##1 !lossLive_n |=> !lossLiveSync)
    else $error("sync lag wrong");
  a_rb_low_value: assert property (regRdEn && regAddr == SLSB_OFS_RB_LOW && sbPortEnable
    |=> regRdData == $past(sbDisable[7:0])) else $error("byte 33 wrong");
  a_rb_high_resv: assert property (regRdEn && regAddr == SLSB_OFS_RB_HIGH |=> regRdData[7:4] == 4'h0)
    else $error("reserved not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Readback checks
  a_rb_mid_value: assert property (
    regRdEn && regAddr == SLSB_OFS_RB_MID && sbPortEnable |=> regRdData == $past(sbDisable[15:8]))
    else $error("byte 34 wrong");
  a_rb_high_value: assert property (
    regRdEn && regAddr == SLSB_OFS_RB_HIGH && sbPortEnable |=> regRdData[3:0] == $past(sbDisable[19:16]))
    else $error("byte 35 wrong");
  a_rb_off_zero: assert property (
    regRdEn && !sbPortEnable && (regAddr == SLSB_OFS_RB_LOW || regAddr == SLSB_OFS_RB_MID ||
    regAddr == SLSB_OFS_RB_HIGH) |=> regRdData == 8'h00)
    else $error("readback not zero");
  a_rd_hit_local: assert property (
    regRdEn && isLocal(regAddr) |=> regRdHit)
    else $error("hit missing");
  a_unmapped_read_zero: assert property (
    regRdEn && !isLocal(regAddr) |=> !regRdHit && regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_rd_data_holds: assert property (
    !regRdEn |=> $stable(regRdData) && $stable(regRdHit))
    else $error("read data moved");
  a_perm_byte_read: assert property (
    regRdEn && regAddr == SLSB_OFS_PERM_LOCK |=> regRdData == {7'h00, $past(permLock)})
    else $error("byte 38 wrong");
  a_clr_byte_read: assert property (
    regRdEn && regAddr == SLSB_OFS_CLR_LOCK |=> regRdData == {6'h00, $past(lossFlag), $past(clrLock)})
    else $error("byte 39 wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Lock checks
  a_perm_no_clr_change: assert property (
    permLock |=> $stable(clrLock))
    else $error("clr lock moved under lock");
  a_perm_loss_kept: assert property (
    permLock && lossFlag |=> lossFlag)
    else $error("flag cleared under lock");
  a_perm_set_cause: assert property (
    $rose(permLock) |-> $past(regWrEn) && $past(regAddr) == SLSB_OFS_PERM_LOCK)
    else $error("lock set without write");
  a_ext_follows_wr: assert property (
    regWrEn && !isLocal(regAddr) && !writeProtect |-> extWrEn)
    else $error("open write dropped");
  a_ext_needs_wr: assert property (
    !regWrEn |-> !extWrEn)
    else $error("strobe without write");
  a_ext_not_local: assert property (
    isLocal(regAddr) |-> !extWrEn)
    else $error("strobe on local byte");
  a_clr_lock_kept: assert property (
    clrLock && !(regWrEn && regAddr == SLSB_OFS_CLR_LOCK && regWrData[0]) |=> clrLock)
    else $error("clr lock fell");
  a_clr_still_open: assert property (
    !permLock && regWrEn && regAddr == SLSB_OFS_CLR_LOCK && regWrData[0] |=> clrLock != $past(clrLock))
    else $error("clr lock not writable");
  a_clr_change_cause: assert property (
    $changed(clrLock) |-> $past(regWrEn) && $past(regAddr) == SLSB_OFS_CLR_LOCK)
    else $error("clr lock moved alone");

  ////////////////////////////////////////////////////////////////////////////
  // Loss flag checks
  a_loss_clear_works: assert property (
    lossFlag && lossLiveSync && !permLock && regWrEn && regAddr == SLSB_OFS_CLR_LOCK && regWrData[1]
    |=> !lossFlag)
    else $error("flag not cleared");
  a_loss_fall_cause: assert property (
    $fell(lossFlag) |-> $past(regWrEn) && $past(regAddr) == SLSB_OFS_CLR_LOCK)
    else $error("flag fell alone");
  a_loss_rise_cause: assert property (
    $rose(lossFlag) |-> $past(lossLiveSync) == 1'b0)
    else $error("flag rose without loss");
  // The live level must recover too, or a cleared flag would set again at once
  a_loss_sync_rise: assert property (
    $rose(lossLive_n) ##1 lossLive_n |=> lossLiveSync)
    else $error("sync recovery wrong");

  c_loss_under_lock: cover property (permLock && lossFlag);
  c_perm_lock: cover property (setPerm ##1 regWrEn);
  c_clr_lock_cycle: cover property (lockToggle ##[1:8] lockToggle);
  c_loss_clear: cover property (lossFlag ##1 lossClear ##1 !lossFlag);
  c_rb_read: cover property (regRdEn && regAddr == SLSB_OFS_RB_MID && sbPortEnable);
endmodule : slsb_regs

// *** tb/slsb_host.sv ***
// SMBus host model: single-byte reads and writes
`timescale 1ns/100ps
module slsb_host (
  input wire logic mclk,
  input wire logic [7:0] regRdData,
  input wire logic extWrEn,
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn
);
  initial {regAddr, regWrData, regWrEn, regRdEn} = '0;
  // Released lines show inverted values so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic e);
    @(posedge mclk) #1 {regAddr, regWrData, regWrEn} = {a, v, 1'b1};
    #1 e = extWrEn;
    @(posedge mclk) #1 {regAddr, regWrData, regWrEn} = {~a, ~v, 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk) #1 {regAddr, regRdEn} = {a, 1'b1};
    @(posedge mclk) #1 {regAddr, regRdEn} = {~a, 1'b0};
    v = regRdData;
  endtask : rd
endmodule : slsb_host

// *** tb/smbus_lock_and_sideband_status_test.sv ***
// Bench for the lock and side-band status slice
`timescale 1ns/100ps
module smbus_lock_and_sideband_status_test;
  import slsb_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [19:0] sbDisable = 20'h5a3c6;
  logic sbPortEnable = 1'b1;
  logic lossLive_n = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData, d;
  logic regWrEn, regRdEn, regRdHit, extWrEn, writeProtect, e, ls;
  int bad_count = 0;
  int n_compared = 0;
  initial forever #12.5 mclk = ~mclk;
  slsb_regs DUT (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdHit(regRdHit),
    .extWrEn(extWrEn), .writeProtect(writeProtect), .sbDisable(sbDisable), .sbPortEnable(sbPortEnable),
    .lossLive_n(lossLive_n), .lossLiveSync(ls), .permLock(), .clrLock(), .lossFlag());
  slsb_host host (.mclk(mclk), .regRdData(regRdData), .extWrEn(extWrEn), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    n_compared++;
    if (s !== x) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // Guard against a hang
  initial begin
    #100us bad_count++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge mclk);
    #1 reset = 1'b0;
    host.rd(SLSB_OFS_RB_LOW, d);
    chk(d, 8'hc6);
    host.rd(SLSB_OFS_RB_MID, d);
    chk(d, 8'ha3);
    host.rd(SLSB_OFS_RB_HIGH, d);
    chk(d, 8'h05);
    sbDisable = ~sbDisable;
    host.rd(SLSB_OFS_RB_LOW, d);
    chk(d, 8'h39);
    sbPortEnable = 1'b0;
    host.rd(SLSB_OFS_RB_HIGH, d);
    chk(d, 8'h00);
    host.rd(8'h24, d);
    chk({d[7:1], regRdHit}, 8'h00);
    $display("readback done");
    host.wr(8'h10, 8'hff, e);
    chk({7'h0, e}, 8'h01);
    host.wr(SLSB_OFS_CLR_LOCK, 8'h01, e);
    chk({7'h0, writeProtect}, 8'h01);
    host.wr(8'h10, 8'hff, e);
    chk({7'h0, e}, 8'h00);
    host.wr(SLSB_OFS_CLR_LOCK, 8'h01, e);
    host.rd(SLSB_OFS_CLR_LOCK, d);
    chk(d, 8'h00);
    $display("clearable lock done");
    lossLive_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk({7'h0, ls}, 8'h00);
    host.wr(SLSB_OFS_CLR_LOCK, 8'h02, e);
    host.rd(SLSB_OFS_CLR_LOCK, d);
    chk(d, 8'h02);
    lossLive_n = 1'b1;
    host.rd(SLSB_OFS_CLR_LOCK, d);
    chk(d, 8'h02);
    host.wr(SLSB_OFS_CLR_LOCK, 8'h02, e);
    host.rd(SLSB_OFS_CLR_LOCK, d);
    chk(d, 8'h00);
    chk({7'h0, ls}, 8'h01);
    $display("loss flag done");
    host.wr(SLSB_OFS_PERM_LOCK, 8'h01, e);
    host.wr(SLSB_OFS_PERM_LOCK, 8'h00, e);
    host.rd(SLSB_OFS_PERM_LOCK, d);
    chk(d, 8'h01);
    host.wr(8'h10, 8'hff, e);
    chk({7'h0, e}, 8'h00);
    host.wr(SLSB_OFS_CLR_LOCK, 8'h01, e);
    host.rd(SLSB_OFS_CLR_LOCK, d);
    chk(d, 8'h00);
    $display("permanent lock done");
    summarize();
  end
endmodule : smbus_lock_and_sideband_status_test
